// [bench/fifo_pair_model.sv]
`timescale 1ns/1ps
module fifo_pair_model (
	input wire logic                        i_ref_clk,
	input wire logic                        i_wr_en,
	input wire logic [ptg_pkg::DATA_W-1:0]  i_wr_data,
	input wire logic                        i_rd_en,
	input wire logic                        i_hold_wr,
	input wire logic                        i_hold_rd,
	input wire logic [31:0]                 i_flip_at,
	input wire logic [ptg_pkg::DATA_W-1:0]  i_flip,
	output logic                            o_almost_full,
	output logic                            o_empty,
	output logic [ptg_pkg::DATA_W-1:0]      o_rd_data
);
	import ptg_pkg::*;
	logic [DATA_W-1:0] store_q[$];
	logic [DATA_W-1:0] w;
	int unsigned       fill = 0;
	// Written words loop back to the read side so that a read run checks what was written.
	assign o_almost_full = i_hold_wr;
	assign o_empty = i_hold_rd || fill == 0;
	initial o_rd_data = '0;
	always @(posedge i_ref_clk) begin
		if (i_rd_en) begin
			w = store_q.pop_front();
			o_rd_data <= (store_q.size() == i_flip_at) ? w ^ i_flip : w;
		end else begin
			// Stale data is never left standing, so a late compare cannot pass by luck.
			o_rd_data <= ~o_rd_data;
		end
		if (i_wr_en)
			store_q.push_back(i_wr_data);
		fill <= store_q.size() + 32'(i_wr_en) - 32'(i_rd_en) + (i_rd_en ? 1 : 0) - (i_rd_en ? 1 : 0);
	end
endmodule // fifo_pair_model

// [bench/pattern_gen_checker_asserts.sv]
`timescale 1ns/1ps
module pattern_gen_checker_asserts (
	input wire logic                        i_ref_clk,
	input wire logic                        i_resetn,
	input wire logic                        i_write_start_pulse,
	input wire logic                        i_read_start_pulse,
	input wire ptg_pkg::xfer_cfg_s          i_cfg,
	input wire logic                        i_wr_fifo_almost_full,
	input wire logic                        i_rd_fifo_empty,
	input wire logic [ptg_pkg::DATA_W-1:0]  i_rd_fifo_read_data,
	input wire logic                        o_wr_fifo_write_enable,
	input wire logic [ptg_pkg::DATA_W-1:0]  o_generated_word,
	input wire logic                        o_rd_fifo_read_enable,
	input wire logic                        o_write_xfer_active,
	input wire logic                        o_read_xfer_active,
	input wire logic                        o_pattern_failure,
	input wire ptg_pkg::fail_info_s         o_fail_info,
	input wire logic [ptg_pkg::CNT_W-1:0]   o_xfer_data_counter,
	input wire logic [ptg_pkg::LBA_W-1:0]   o_xfer_sector_address
);
	import ptg_pkg::*;
	logic wr_act;
	logic at_end;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	assign wr_act = o_write_xfer_active;
	assign at_end = o_xfer_data_counter == i_cfg.end_size_a;
	property p_start; !wr_act && !o_read_xfer_active && i_write_start_pulse |=> wr_act; endproperty
	a_start: assert property (p_start) else $error("write run did not start");
	property p_hold; wr_act && !at_end |=> wr_act; endproperty
	a_hold: assert property (p_hold) else $error("write run dropped early");
	property p_pause; o_wr_fifo_write_enable |-> !$past(i_wr_fifo_almost_full); endproperty
	a_pause: assert property (p_pause) else $error("beat written while almost full");
	property p_flow; (wr_act && !i_wr_fifo_almost_full) [*2] |=> o_wr_fifo_write_enable || !wr_act; endproperty
	a_flow: assert property (p_flow) else $error("beat withheld with room free");
	property p_count; wr_act && $past(wr_act) |-> o_xfer_data_counter == $past(o_xfer_data_counter) +
		32'(o_wr_fifo_write_enable); endproperty
	a_count: assert property (p_count) else $error("counter does not follow writes");
	property p_end; wr_act && at_end |=> !wr_act && !o_wr_fifo_write_enable; endproperty
	a_end: assert property (p_end) else $error("write run overran its size");
	property p_rd_en; o_read_xfer_active && !at_end |-> o_rd_fifo_read_enable == !i_rd_fifo_empty; endproperty
	a_rd_en: assert property (p_rd_en) else $error("read enable not inverse of empty");
	property p_rd_count; o_rd_fifo_read_enable |=> o_xfer_data_counter == $past(o_xfer_data_counter) + 1; endproperty
	a_rd_count: assert property (p_rd_count) else $error("counter does not follow reads");
	property p_addr; wr_act && $past(wr_act) && $changed(o_xfer_sector_address) |->
		o_xfer_sector_address == $past(o_xfer_sector_address) + 1; endproperty
	a_addr: assert property (p_addr) else $error("sector address jumped");
	property p_sticky; o_pattern_failure && !i_read_start_pulse |=> o_pattern_failure; endproperty
	a_sticky: assert property (p_sticky) else $error("failure flag lost");
	c_done: cover property (wr_act ##1 !wr_act);
	c_paused: cover property (wr_act && i_wr_fifo_almost_full);
	c_failed: cover property ($rose(o_pattern_failure));
endmodule // pattern_gen_checker_asserts

bind pattern_gen_checker pattern_gen_checker_asserts u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
	.i_write_start_pulse(i_write_start_pulse), .i_read_start_pulse(i_read_start_pulse), .i_cfg(i_cfg),
	.i_wr_fifo_almost_full(i_wr_fifo_almost_full), .i_rd_fifo_empty(i_rd_fifo_empty),
	.i_rd_fifo_read_data(i_rd_fifo_read_data), .o_wr_fifo_write_enable(o_wr_fifo_write_enable),
	.o_generated_word(o_generated_word), .o_rd_fifo_read_enable(o_rd_fifo_read_enable),
	.o_write_xfer_active(o_write_xfer_active), .o_read_xfer_active(o_read_xfer_active),
	.o_pattern_failure(o_pattern_failure), .o_fail_info(o_fail_info), .o_xfer_data_counter(o_xfer_data_counter),
	.o_xfer_sector_address(o_xfer_sector_address));

// [bench/test_pattern_gen_checker.sv]
`timescale 1ns/1ps
module test_pattern_gen_checker;
	import ptg_pkg::*;
	logic              i_ref_clk, i_resetn, wr_start, rd_start, afull, empty, hold_wr, hold_rd;
	logic              wr_en, rd_en, wr_act, rd_act, fail;
	xfer_cfg_s         cfg;
	fail_info_s        finfo;
	logic [DATA_W-1:0] gen_word, rd_data, flip;
	logic [CNT_W-1:0]  cnt;
	logic [LBA_W-1:0]  addr, lba;
	logic [31:0]       flip_at, seed, r;
	int                error_cnt, samples_checked, nb, sel;
	pattern_gen_checker i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_write_start_pulse(wr_start),
		.i_read_start_pulse(rd_start), .i_cfg(cfg), .i_wr_fifo_almost_full(afull), .i_rd_fifo_empty(empty),
		.i_rd_fifo_read_data(rd_data), .o_wr_fifo_write_enable(wr_en), .o_generated_word(gen_word),
		.o_rd_fifo_read_enable(rd_en), .o_write_xfer_active(wr_act), .o_read_xfer_active(rd_act),
		.o_pattern_failure(fail), .o_fail_info(finfo), .o_xfer_data_counter(cnt), .o_xfer_sector_address(addr));
	fifo_pair_model u_fifo (.i_ref_clk(i_ref_clk), .i_wr_en(wr_en), .i_wr_data(gen_word), .i_rd_en(rd_en),
		.i_hold_wr(hold_wr), .i_hold_rd(hold_rd), .i_flip_at(flip_at), .i_flip(flip), .o_almost_full(afull),
		.o_empty(empty), .o_rd_data(rd_data));
	initial begin
		i_ref_clk = 0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	function logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [DATA_W-1:0] model_word(int s, logic [LBA_W-1:0] a, int b);
		logic [DATA_W-1:0] w;
		logic [31:0]       v;
		w = '0;
		for (int l = 0; l < 8; l++) begin
			v = {a[24:0], 4'(b), 3'(l)};
			if (s == 1)
				v = ~v;
			else if (s == 3)
				v = '1;
			else if (s == 4) begin
				v = (l % 2) ? {a[31:16], ~a[15:0]} : {~a[31:16], a[15:0]};
				for (int k = 0; k < 4 * b + l / 2; k++)
					v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
			end else if (s != 0)
				v = '0;
			w[32 * l +: 32] = v;
		end
		if (b == 0)
			w[63:0] = {16'h0, a};
		return w;
	endfunction
	task automatic chk(logic [DATA_W-1:0] g, logic [DATA_W-1:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task give_verdict();
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task idle_wait();
		for (int i = 0; i < 3000 && (wr_act || rd_act); i++)
			@(negedge i_ref_clk);
	endtask
	task automatic run(int k);
		int n;
		n = 16 * (k % 3) + k + 1;
		sel = k % 6;
		lba = {16'(nxt()), nxt()};
		nb = 0;
		cfg = '{32'(n), 3'(sel), lba};
		flip = '0;
		flip[70] = (k == 6);
		flip_at = 32'(n - 4);
		wr_start = 1;
		@(negedge i_ref_clk) wr_start = 0;
		@(negedge i_ref_clk) wr_start = 1;
		@(negedge i_ref_clk) wr_start = 0;
		idle_wait();
		chk(256'(nb), 256'(n));
		chk(256'(addr), 256'(lba + 48'(n / 16)));
		rd_start = 1;
		@(negedge i_ref_clk) rd_start = 0;
		@(negedge i_ref_clk);
		idle_wait();
		chk(256'(fail), 256'(k == 6));
		chk(256'(cnt), 256'(n));
		if (k == 6)
			chk(256'(finfo), 256'({32'h3, 8'h04}));
	endtask
	always @(negedge i_ref_clk) begin
		r = nxt();
		hold_wr <= r[0] & r[1];
		hold_rd <= r[2] & r[3];
		if (wr_en) begin
			chk(gen_word, model_word(sel, lba + 48'(nb / 16), nb % 16));
			chk(256'(cnt), 256'(nb + 1));
			nb++;
		end
	end
	initial begin
		seed = 32'd38;
		{i_resetn, wr_start, rd_start, hold_wr, hold_rd} = '0;
		{cfg, flip, flip_at, error_cnt, samples_checked, nb, sel} = '0;
		repeat (2) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk(256'({wr_en, rd_en, wr_act, rd_act, fail}), '0);
		i_resetn = 1;
		@(negedge i_ref_clk);
		for (int k = 0; k < 8; k++)
			run(k);
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		error_cnt++;
		give_verdict();
	end
endmodule // test_pattern_gen_checker

// [common/ptg_pkg.sv]
package ptg_pkg;

	localparam int DATA_W           = 256;
	localparam int LANE_W           = 32;
	localparam int LANES            = 8;
	localparam int LBA_W            = 48;
	localparam int CNT_W            = 32;
	localparam int HDR_W            = 64;
	localparam int BEATS_PER_SECTOR = 16;
	localparam int BEAT_W           = 4;
	localparam int LFSR_STEPS       = 4;
	localparam int INC_LBA_BITS     = 25;

	// Beat index that closes a sector, and the values every counter takes after reset.
	localparam logic [BEAT_W-1:0] LAST_BEAT   = 4'hf;
	localparam logic [BEAT_W-1:0] HEADER_BEAT = 4'h0;
	localparam logic [CNT_W-1:0]  CNT_RESET   = 32'h0000_0000;
	localparam logic [LBA_W-1:0]  LBA_RESET   = 48'h0000_0000_0000;
	localparam logic [LANE_W-1:0] LFSR_RESET  = 32'h0000_0000;

	typedef enum logic [2:0] {
		PAT_INC  = 3'h0,
		PAT_DEC  = 3'h1,
		PAT_ZERO = 3'h2,
		PAT_ONE  = 3'h3,
		PAT_LFSR = 3'h4
	} pattern_e;

	typedef struct packed {
		logic [CNT_W-1:0] end_size_a;
		logic [2:0]       pattern_select;
		logic [LBA_W-1:0] start_lba;
	} xfer_cfg_s;

	typedef struct packed {
		logic [CNT_W-1:0] beat;
		logic [LANES-1:0] lane_mask;
	} fail_info_s;

	// Fibonacci LFSR, taps 32, 22, 2, 1.
	function automatic logic [LANE_W-1:0] lfsr_step(input logic [LANE_W-1:0] s);
		return {s[LANE_W-2:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Set zero takes true low half and inverted high half; set one the reverse.
	function automatic logic [LANE_W-1:0] lfsr_seed(input logic [LANE_W-1:0] lba, input logic odd_set);
		return odd_set ? {lba[31:16], ~lba[15:0]} : {~lba[31:16], lba[15:0]};
	endfunction

endpackage

// [hdl/lfsr_lane_gen.sv]
`timescale 1ns/1ps
module lfsr_lane_gen (
	input  wire logic [ptg_pkg::LANE_W-1:0] i_base_even,
	input  wire logic [ptg_pkg::LANE_W-1:0] i_base_odd,
	output logic      [ptg_pkg::DATA_W-1:0] o_lanes,
	output logic      [ptg_pkg::LANE_W-1:0] o_next_even,
	output logic      [ptg_pkg::LANE_W-1:0] o_next_odd
);
	import ptg_pkg::*;

	logic [LANE_W-1:0] lfsr_even_lanes;
	logic [LANE_W-1:0] lfsr_odd_lanes;

	// Four look-ahead steps per set so a whole beat is ready in one clock.
	always_comb begin
		lfsr_even_lanes = i_base_even;
		lfsr_odd_lanes  = i_base_odd;
		o_lanes         = '0;
		for (int k = 0; k < LFSR_STEPS; k++) begin
			o_lanes[2*k*LANE_W +: LANE_W]     = lfsr_even_lanes;
			o_lanes[(2*k+1)*LANE_W +: LANE_W] = lfsr_odd_lanes;
			lfsr_even_lanes                   = lfsr_step(lfsr_even_lanes);
			lfsr_odd_lanes                    = lfsr_step(lfsr_odd_lanes);
		end
		o_next_even = lfsr_even_lanes;
		o_next_odd  = lfsr_odd_lanes;
	end

endmodule // lfsr_lane_gen

// [hdl/pattern_gen_checker.sv]
// How it works
// - Write start pulse latches write-active flag high.
// - Write enable follows inverse almost-full while active.
// - Counter counts writes; end size stops transfer.
// - Read enable is inverse of read empty while a read run is short of end size.
// - Read enable advances counter and expected pattern.
// - Sector: header words 0-1, data 2-127.
// - Header value is sector LBA.
// - Start LBA loads transfer address register.
// - Address increments at each sector's last beat.
// - Three-bit select picks one of five patterns.
// - Increment uses low address bits and counter.
// - Decrement is inverse of increment.
// - Two LFSR sets interleave on even/odd lanes.
// - LFSR seeds mix true and inverted address halves.
// - All eight LFSR lanes produced per clock.
// - Pattern is expected read value; mismatch flags failure.
// - 256-bit bus, single user clock domain.
`timescale 1ns/1ps
module pattern_gen_checker (
	input  wire logic                      i_ref_clk,
	input  wire logic                      i_resetn,
	input  wire logic                      i_write_start_pulse,
	input  wire logic                      i_read_start_pulse,
	input  wire ptg_pkg::xfer_cfg_s        i_cfg,
	input  wire logic                      i_wr_fifo_almost_full,
	input  wire logic                      i_rd_fifo_empty,
	input  wire logic [ptg_pkg::DATA_W-1:0] i_rd_fifo_read_data,
	output logic                           o_wr_fifo_write_enable,
	output logic      [ptg_pkg::DATA_W-1:0] o_generated_word,
	output logic                           o_rd_fifo_read_enable,
	output logic                           o_write_xfer_active,
	output logic                           o_read_xfer_active,
	output logic                           o_pattern_failure,
	output ptg_pkg::fail_info_s            o_fail_info,
	output logic      [ptg_pkg::CNT_W-1:0]  o_xfer_data_counter,
	output logic      [ptg_pkg::LBA_W-1:0]  o_xfer_sector_address
);
	import ptg_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ  = 2'b10
	} xfer_state_e;

	// Control group.
	xfer_state_e       state_q;
	xfer_state_e       state_d;
	xfer_cfg_s         cfg_q;
	xfer_cfg_s         cfg_d;
	logic [CNT_W-1:0]  cnt_q;
	logic [CNT_W-1:0]  cnt_d;
	logic [LBA_W-1:0]  addr_q;
	logic [LBA_W-1:0]  addr_d;
	logic [LANE_W-1:0] lfsr_even_q;
	logic [LANE_W-1:0] lfsr_even_d;
	logic [LANE_W-1:0] lfsr_odd_q;
	logic [LANE_W-1:0] lfsr_odd_d;
	logic              wr_active_q;
	logic              wr_active_d;
	logic              rd_active_q;
	logic              rd_active_d;

	// Write output group.
	logic              wr_en_q;
	logic              wr_en_d;
	logic [DATA_W-1:0] word_q;
	logic [DATA_W-1:0] word_d;

	// Checker group.
	logic [DATA_W-1:0] expected_q;
	logic [DATA_W-1:0] expected_d;
	logic              cmp_valid_q;
	logic              cmp_valid_d;
	logic [CNT_W-1:0]  cmp_beat_q;
	logic [CNT_W-1:0]  cmp_beat_d;
	logic              fail_q;
	logic              fail_d;
	fail_info_s        fail_info_q;
	fail_info_s        fail_info_d;

	// Shared combinational terms.
	logic [BEAT_W-1:0] beat;
	logic              remaining;
	logic              wr_issue;
	logic              rd_issue;
	logic              step;
	logic              start_wr;
	logic              start_rd;
	logic [LANE_W-1:0] base_even;
	logic [LANE_W-1:0] base_odd;
	logic [LANE_W-1:0] next_even;
	logic [LANE_W-1:0] next_odd;
	logic [DATA_W-1:0] lfsr_lanes;
	logic [DATA_W-1:0] pattern_word;
	logic [LANES-1:0]  lane_miss;

	assign beat      = cnt_q[BEAT_W-1:0];
	assign remaining = (cnt_q != cfg_q.end_size_a);
	assign start_wr  = (state_q == ST_IDLE) && i_write_start_pulse;
	assign start_rd  = (state_q == ST_IDLE) && i_read_start_pulse && !i_write_start_pulse;

	// Pausing is decided from the current flag, so the write FIFO must leave room for one beat in flight.
	assign wr_issue = (state_q == ST_WRITE) && !i_wr_fifo_almost_full && remaining;
	// Kept combinational: a registered enable would lag empty by a cycle and read past the last word.
	assign rd_issue = (state_q == ST_READ) && !i_rd_fifo_empty && remaining;
	assign step     = wr_issue || rd_issue;

	// Each sector restarts both sequences from its own address.
	assign base_even = (beat == HEADER_BEAT) ? lfsr_seed(addr_q[LANE_W-1:0], 1'b0) : lfsr_even_q;
	assign base_odd  = (beat == HEADER_BEAT) ? lfsr_seed(addr_q[LANE_W-1:0], 1'b1) : lfsr_odd_q;

	lfsr_lane_gen u_lfsr (
		.i_base_even (base_even),
		.i_base_odd  (base_odd),
		.o_lanes     (lfsr_lanes),
		.o_next_even (next_even),
		.o_next_odd  (next_odd)
	);

	pattern_word_gen u_pattern (
		.i_pattern_select (cfg_q.pattern_select),
		.i_sector_lba     (addr_q),
		.i_beat           (beat),
		.i_lfsr_lanes     (lfsr_lanes),
		.o_word           (pattern_word)
	);

	always_comb begin
		state_d     = state_q;
		cfg_d       = cfg_q;
		cnt_d       = cnt_q;
		addr_d      = addr_q;
		lfsr_even_d = lfsr_even_q;
		lfsr_odd_d  = lfsr_odd_q;
		unique case (state_q)
			ST_IDLE: begin
				// Configuration is captured at start so register writes mid-run cannot tear a transfer.
				if (start_wr || start_rd) begin
					cfg_d  = i_cfg;
					cnt_d  = CNT_RESET;
					addr_d = i_cfg.start_lba;
				end
				if (start_wr) begin
					state_d = ST_WRITE;
				end else if (start_rd) begin
					state_d = ST_READ;
				end
			end
			ST_WRITE, ST_READ: begin
				if (!remaining) begin
					state_d = ST_IDLE;
				end
				if (step) begin
					cnt_d       = cnt_q + 1'b1;
					lfsr_even_d = next_even;
					lfsr_odd_d  = next_odd;
					if (beat == LAST_BEAT) begin
						addr_d = addr_q + 1'b1;
					end
				end
			end
		endcase
		wr_active_d = (state_d == ST_WRITE);
		rd_active_d = (state_d == ST_READ);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_q     <= ST_IDLE;
			cfg_q       <= '0;
			cnt_q       <= CNT_RESET;
			addr_q      <= LBA_RESET;
			lfsr_even_q <= LFSR_RESET;
			lfsr_odd_q  <= LFSR_RESET;
			wr_active_q <= 1'b0;
			rd_active_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			cfg_q       <= cfg_d;
			cnt_q       <= cnt_d;
			addr_q      <= addr_d;
			lfsr_even_q <= lfsr_even_d;
			lfsr_odd_q  <= lfsr_odd_d;
			wr_active_q <= wr_active_d;
			rd_active_q <= rd_active_d;
		end
	end

	always_comb begin
		wr_en_d = wr_issue;
		word_d  = wr_issue ? pattern_word : word_q;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			wr_en_q <= 1'b0;
			word_q  <= '0;
		end else begin
			wr_en_q <= wr_en_d;
			word_q  <= word_d;
		end
	end

	// Read data arrives one clock after its enable, so the expected word is held for that clock.
	always_comb begin
		expected_d  = rd_issue ? pattern_word : expected_q;
		cmp_valid_d = rd_issue;
		cmp_beat_d  = rd_issue ? cnt_q : cmp_beat_q;
		lane_miss   = '0;
		for (int l = 0; l < LANES; l++) begin
			lane_miss[l] = cmp_valid_q && (i_rd_fifo_read_data[l*LANE_W +: LANE_W] != expected_q[l*LANE_W +: LANE_W]);
		end
		// A new read run clears the flag, but a miss in the same cycle still sets it.
		fail_d      = (start_rd ? 1'b0 : fail_q) | (|lane_miss);
		fail_info_d = start_rd ? '0 : fail_info_q;
		if ((|lane_miss) && (!fail_q || start_rd)) begin
			fail_info_d.beat      = cmp_beat_q;
			fail_info_d.lane_mask = lane_miss;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			expected_q  <= '0;
			cmp_valid_q <= 1'b0;
			cmp_beat_q  <= CNT_RESET;
			fail_q      <= 1'b0;
			fail_info_q <= '0;
		end else begin
			expected_q  <= expected_d;
			cmp_valid_q <= cmp_valid_d;
			cmp_beat_q  <= cmp_beat_d;
			fail_q      <= fail_d;
			fail_info_q <= fail_info_d;
		end
	end

	assign o_wr_fifo_write_enable = wr_en_q;
	assign o_generated_word       = word_q;
	assign o_rd_fifo_read_enable  = rd_issue;
	assign o_write_xfer_active    = wr_active_q;
	assign o_read_xfer_active     = rd_active_q;
	assign o_pattern_failure      = fail_q;
	assign o_fail_info            = fail_info_q;
	assign o_xfer_data_counter    = cnt_q;
	assign o_xfer_sector_address  = addr_q;

endmodule // pattern_gen_checker

// [hdl/pattern_word_gen.sv]
`timescale 1ns/1ps
module pattern_word_gen (
	input  wire logic [2:0]                 i_pattern_select,
	input  wire logic [ptg_pkg::LBA_W-1:0]  i_sector_lba,
	input  wire logic [ptg_pkg::BEAT_W-1:0] i_beat,
	input  wire logic [ptg_pkg::DATA_W-1:0] i_lfsr_lanes,
	output logic      [ptg_pkg::DATA_W-1:0] o_word
);
	import ptg_pkg::*;

	logic [LANE_W-1:0] inc_lane;

	always_comb begin
		inc_lane = '0;
		o_word   = '0;
		for (int l = 0; l < LANES; l++) begin
			// Word index in the sector sits below the low address bits.
			inc_lane = {i_sector_lba[INC_LBA_BITS-1:0], i_beat, l[2:0]};
			case (i_pattern_select)
				PAT_INC:  o_word[l*LANE_W +: LANE_W] = inc_lane;
				PAT_DEC:  o_word[l*LANE_W +: LANE_W] = ~inc_lane;
				PAT_ZERO: o_word[l*LANE_W +: LANE_W] = '0;
				PAT_ONE:  o_word[l*LANE_W +: LANE_W] = '1;
				PAT_LFSR: o_word[l*LANE_W +: LANE_W] = i_lfsr_lanes[l*LANE_W +: LANE_W];
				default:  o_word[l*LANE_W +: LANE_W] = '0;
			endcase
		end
		if (i_beat == HEADER_BEAT) begin
			o_word[HDR_W-1:0] = {{(HDR_W-LBA_W){1'b0}}, i_sector_lba};
		end
	end

endmodule // pattern_word_gen
